// ===== logic/pwsd_regs.sv
// Register bank: pulse width, edge detect enables, line change status, soft reset.
// Assumes a synchronous 8-bit local register port on clk and a mode input.
`timescale 1ns/1ns
module pwsd_regs
	import pwsd_pkg::*;
#(
	parameter int unsigned RESET_CLKS = SOFT_RESET_CLKS
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire pwsd_pkg::pwsd_bus_req_t bus_req,
	input  wire logic [1:0]            channel_select,
	output logic [7:0]                 bus_rdata,
	input  wire pwsd_pkg::pwsd_mode_t  port_mode,
	input  wire logic                  signal_change_irq_enable,
	input  wire pwsd_pkg::pwsd_lines_t host_lines,
	input  wire logic                  short_pulse_start,
	input  wire logic                  ack_pulse_start,
	output logic                       short_pulse_out,
	output logic                       ack_pulse_out,
	output logic                       signal_change_irq,
	output logic                       soft_reset_out
);
	import pwsd_pkg::*;

	logic [7:0] pulse_width_ff;
	logic [7:0] nxt_pulse_width;
	logic [3:0] fall_en_ff;
	logic [3:0] nxt_fall_en;
	logic [3:0] rise_en_ff;
	logic [3:0] nxt_rise_en;
	logic [3:0] status_ff;
	logic [3:0] nxt_status;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       irq_ff;
	logic       nxt_irq;
	logic       short_ff;
	logic       nxt_short;
	logic       ack_ff;
	logic       nxt_ack;
	logic       sreset_ff;
	logic       nxt_sreset;
	logic [7:0] sreset_cnt_ff;
	logic [7:0] nxt_sreset_cnt;
	logic [3:0] rise_pulse;
	logic [3:0] fall_pulse;
	logic       pulse_active;
	logic       compat;
	logic       manual;
	logic       start_pulse;

	function automatic logic hit(input pwsd_bus_req_t req, input logic [7:0] off);
		hit = (req.addr == off);
	endfunction

	pwsd_line_sync #(
		.WIDTH (LINE_COUNT)
	) u_sync (
		.clk        (clk),
		.rst_n      (rst_n),
		.lines_in   (host_lines),
		.rise_pulse (rise_pulse),
		.fall_pulse (fall_pulse)
	);

	assign compat      = (port_mode == PWSD_MODE_COMPAT);
	assign manual      = (port_mode == PWSD_MODE_MANUAL);
	assign start_pulse = compat ? ack_pulse_start : short_pulse_start;

	// One timer serves both uses; the mode picks which output carries it.
	pwsd_pulse_timer #(
		.WIDTH (8)
	) u_timer (
		.clk    (clk),
		.rst_n  (rst_n),
		.start  (start_pulse),
		.length (pulse_width_ff),
		.active (pulse_active)
	);

	always_comb
	begin
		nxt_pulse_width = pulse_width_ff;
		nxt_fall_en     = fall_en_ff;
		nxt_rise_en     = rise_en_ff;
		nxt_status      = status_ff;
		nxt_sreset      = 1'b0;
		nxt_sreset_cnt  = sreset_cnt_ff;
		nxt_rdata       = rdata_ff;
		if (bus_req.wr)
		begin
			if (hit(bus_req, OFF_PULSE_WIDTH))
				nxt_pulse_width = bus_req.wdata;
			if (hit(bus_req, OFF_FALL_ENABLE))
				nxt_fall_en = bus_req.wdata[3:0] & LOW_NIBBLE_MASK;
			if (hit(bus_req, OFF_RISE_ENABLE))
				nxt_rise_en = bus_req.wdata[3:0];
			if (hit(bus_req, OFF_LINE_STATUS))
				nxt_status = '0;
		end
		// Only in manual mode do enabled edges latch; a set beats a same-cycle clear.
		if (manual)
			nxt_status = nxt_status | (fall_pulse & fall_en_ff)
				| (rise_pulse & rise_en_ff);
		// The only command is reset, and only through channel 2 or 3.
		if (bus_req.wr && hit(bus_req, OFF_SOFT_RESET) && bus_req.wdata == SOFT_RESET_CODE
			&& (channel_select == CHAN_RESET_LO || channel_select == CHAN_RESET_HI))
			nxt_sreset_cnt = 8'(RESET_CLKS);
		else if (sreset_cnt_ff != '0)
			nxt_sreset_cnt = sreset_cnt_ff - 8'h01;
		nxt_sreset = (nxt_sreset_cnt != '0);
		nxt_irq    = signal_change_irq_enable && manual && (status_ff != '0);
		nxt_short  = pulse_active && !compat;
		nxt_ack    = pulse_active && compat;
		if (bus_req.rd)
		begin
			if (hit(bus_req, OFF_PULSE_WIDTH))
				nxt_rdata = pulse_width_ff;
			else if (hit(bus_req, OFF_FALL_ENABLE))
				nxt_rdata = {4'h0, fall_en_ff};
			else if (hit(bus_req, OFF_RISE_ENABLE))
				nxt_rdata = {4'h0, rise_en_ff};
			else if (hit(bus_req, OFF_LINE_STATUS))
				nxt_rdata = {4'h0, status_ff};
			else
				nxt_rdata = REG_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_width_ff <= PULSE_WIDTH_RESET;
			fall_en_ff     <= '0;
			rise_en_ff     <= '0;
			status_ff      <= '0;
			rdata_ff       <= REG_RESET;
			irq_ff         <= 1'b0;
			short_ff       <= 1'b0;
			ack_ff         <= 1'b0;
			sreset_ff      <= 1'b0;
			sreset_cnt_ff  <= '0;
		end
		else if (sreset_ff)
		begin
			pulse_width_ff <= PULSE_WIDTH_RESET;
			fall_en_ff     <= '0;
			rise_en_ff     <= '0;
			status_ff      <= '0;
			rdata_ff       <= REG_RESET;
			irq_ff         <= 1'b0;
			short_ff       <= 1'b0;
			ack_ff         <= 1'b0;
			sreset_ff      <= nxt_sreset;
			sreset_cnt_ff  <= nxt_sreset_cnt;
		end
		else
		begin
			pulse_width_ff <= nxt_pulse_width;
			fall_en_ff     <= nxt_fall_en;
			rise_en_ff     <= nxt_rise_en;
			status_ff      <= nxt_status;
			rdata_ff       <= nxt_rdata;
			irq_ff         <= nxt_irq;
			short_ff       <= nxt_short;
			ack_ff         <= nxt_ack;
			sreset_ff      <= nxt_sreset;
			sreset_cnt_ff  <= nxt_sreset_cnt;
		end
	end

	assign bus_rdata         = rdata_ff;
	assign signal_change_irq = irq_ff;
	assign short_pulse_out   = short_ff;
	assign ack_pulse_out     = ack_ff;
	assign soft_reset_out    = sreset_ff;
endmodule

// ===== inc/pwsd_pkg.sv
// Package for the pulse width and signal detect register bank.
// Assumes an 8-bit local register port and a single 25 MHz system clock.
package pwsd_pkg;
	localparam int unsigned CLK_HZ              = 25000000;
	localparam int unsigned SHORT_PULSE_NS      = 500;
	localparam int unsigned SHORT_PULSE_CLKS    = (SHORT_PULSE_NS * (CLK_HZ / 1000000)) / 1000;
	localparam logic [7:0]  PULSE_WIDTH_RESET   = 8'(SHORT_PULSE_CLKS - 2);
	localparam logic [7:0]  OFF_SOFT_RESET      = 8'h05;
	localparam logic [7:0]  OFF_FALL_ENABLE     = 8'h2C;
	localparam logic [7:0]  OFF_RISE_ENABLE     = 8'h2D;
	localparam logic [7:0]  OFF_PULSE_WIDTH     = 8'h2E;
	localparam logic [7:0]  OFF_LINE_STATUS     = 8'h2F;
	localparam logic [7:0]  SOFT_RESET_CODE     = 8'h81;
	localparam logic [7:0]  REG_RESET           = 8'h00;
	localparam logic [3:0]  LOW_NIBBLE_MASK     = 4'hF;
	localparam logic [1:0]  CHAN_RESET_LO       = 2'h2;
	localparam logic [1:0]  CHAN_RESET_HI       = 2'h3;
	localparam int unsigned SOFT_RESET_CLKS     = 16;
	localparam int unsigned LINE_COUNT          = 4;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pwsd_bus_req_t;

	typedef struct packed
	{
		logic negotiation_active_line;
		logic host_restart_line;
		logic host_busy_line;
		logic host_strobe_line;
	} pwsd_lines_t;

	typedef enum logic [1:0]
	{
		PWSD_MODE_COMPAT,
		PWSD_MODE_NIBBLE_BYTE,
		PWSD_MODE_ECP_EPP,
		PWSD_MODE_MANUAL
	} pwsd_mode_t;
endpackage

// ===== logic/pwsd_line_sync.sv
// Three-stage synchroniser and edge detector for the monitored host lines.
// Assumes lines are asynchronous to clk.
`timescale 1ns/1ns
module pwsd_line_sync #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] lines_in,
	output logic      [WIDTH-1:0] rise_pulse,
	output logic      [WIDTH-1:0] fall_pulse
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	logic [WIDTH-1:0] stable_ff;
	logic [WIDTH-1:0] nxt_stable;

	// A change counts once the second and third stages agree.
	always_comb
	begin
		nxt_stable = stable_ff;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s2_ff[i] == s3_ff[i])
				nxt_stable[i] = s3_ff[i];
		end
		rise_pulse = nxt_stable & ~stable_ff;
		fall_pulse = ~nxt_stable & stable_ff;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_ff     <= '1;
			s2_ff     <= '1;
			s3_ff     <= '1;
			stable_ff <= '1;
		end
		else
		begin
			s1_ff     <= lines_in;
			s2_ff     <= s1_ff;
			s3_ff     <= s2_ff;
			stable_ff <= nxt_stable;
		end
	end
endmodule

// ===== logic/pwsd_pulse_timer.sv
// Pulse generator: output high for a programmed number of clocks.
// Assumes start is a one-cycle pulse on clk.
`timescale 1ns/1ns
module pwsd_pulse_timer #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] length,
	output logic                  active
);
	logic [WIDTH-1:0] count_ff;
	logic [WIDTH-1:0] nxt_count;
	logic             active_ff;
	logic             nxt_active;

	// Loads the length and counts down; zero length gives no pulse.
	always_comb
	begin
		nxt_count  = count_ff;
		nxt_active = active_ff;
		if (start && !active_ff)
		begin
			nxt_count  = length;
			nxt_active = (length != '0);
		end
		else if (active_ff)
		begin
			nxt_count  = count_ff - WIDTH'(1);
			nxt_active = (count_ff != WIDTH'(1));
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_ff  <= '0;
			active_ff <= 1'b0;
		end
		else
		begin
			count_ff  <= nxt_count;
			active_ff <= nxt_active;
		end
	end

	assign active = active_ff;
endmodule

// ===== testbench/pwsd_regs_sva.sv
// Checker for the pulse width and signal detect register bank.
// Assumes it is bound to pwsd_regs and sees only that module's ports.
`timescale 1ns/1ns
module pwsd_regs_sva
	import pwsd_pkg::*;
#(
	parameter int unsigned RESET_CLKS = 2
) (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire pwsd_pkg::pwsd_bus_req_t bus_req,
	input wire logic [1:0]              channel_select,
	input wire logic [7:0]              bus_rdata,
	input wire pwsd_pkg::pwsd_mode_t    port_mode,
	input wire logic                    signal_change_irq_enable,
	input wire pwsd_pkg::pwsd_lines_t   host_lines,
	input wire logic                    short_pulse_start,
	input wire logic                    ack_pulse_start,
	input wire logic                    short_pulse_out,
	input wire logic                    ack_pulse_out,
	input wire logic                    signal_change_irq,
	input wire logic                    soft_reset_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr(a);
		bus_req.wr && bus_req.addr == a && !soft_reset_out;
	endsequence
	sequence s_rd(a);
		bus_req.rd && bus_req.addr == a && !soft_reset_out;
	endsequence
	AST_SHORT_GO: assert property (short_pulse_start && port_mode != PWSD_MODE_COMPAT
		|-> ##2 short_pulse_out) else $error("short pulse did not start");
	AST_ACK_GO: assert property (ack_pulse_start && port_mode == PWSD_MODE_COMPAT
		|-> ##2 ack_pulse_out) else $error("ack pulse did not start");
	AST_STATUS_HI: assert property (s_rd(OFF_LINE_STATUS) |-> ##2 bus_rdata[7:4] == 4'h0)
		else $error("status upper bits not zero");
	AST_FALL_HI: assert property (s_rd(OFF_FALL_ENABLE) |-> ##2 bus_rdata[7:4] == 4'h0)
		else $error("falling enable upper bits not zero");
	AST_CLEAR: assert property (s_wr(OFF_LINE_STATUS) |-> ##2 !signal_change_irq)
		else $error("status write did not clear");
	AST_MODE: assert property ((port_mode != PWSD_MODE_MANUAL)[*2] |-> !signal_change_irq)
		else $error("irq outside manual mode");
	AST_IRQ_EN: assert property ((!signal_change_irq_enable)[*2] |-> !signal_change_irq)
		else $error("irq while disabled");
	AST_SRST_GO: assert property (s_wr(OFF_SOFT_RESET) ##0 bus_req.wdata == SOFT_RESET_CODE
		&& channel_select[1] |-> ##[1:3] soft_reset_out) else $error("soft reset missing");
	AST_SRST_REFUSE: assert property (s_wr(OFF_SOFT_RESET) ##0 !(channel_select[1]
		&& bus_req.wdata == SOFT_RESET_CODE) |-> ##1 !soft_reset_out ##1 !soft_reset_out)
		else $error("soft reset on refused write");
endmodule

bind pwsd_regs pwsd_regs_sva #(.RESET_CLKS(RESET_CLKS)) u_pwsd_regs_sva (.clk(clk),
	.rst_n(rst_n), .bus_req(bus_req), .channel_select(channel_select), .bus_rdata(bus_rdata),
	.port_mode(port_mode), .signal_change_irq_enable(signal_change_irq_enable),
	.host_lines(host_lines), .short_pulse_start(short_pulse_start),
	.ack_pulse_start(ack_pulse_start), .short_pulse_out(short_pulse_out),
	.ack_pulse_out(ack_pulse_out), .signal_change_irq(signal_change_irq),
	.soft_reset_out(soft_reset_out));

// ===== testbench/pwsd_host_model.sv
// Host side model that drives the four monitored host lines.
// Assumes the bench gives the wanted line levels as a vector.
`timescale 1ns/1ns
module pwsd_host_model
	import pwsd_pkg::*;
(
	input  wire logic [3:0]         want,
	output pwsd_pkg::pwsd_lines_t   lines
);
	// Lines move at an odd delay so they stay unrelated to the clock.
	assign #7 lines = pwsd_lines_t'(want);
endmodule

// ===== testbench/pulse_width_and_signal_detect_tb_top.sv
// Testbench for the pulse width and signal detect register bank.
// Assumes a 25 MHz clock and the host model on the monitored lines.
`timescale 1ns/1ns
module pulse_width_and_signal_detect_tb_top;
	import pwsd_pkg::*;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	pwsd_bus_req_t bus_req = '0;
	logic [1:0]    chan = 2'h0;
	pwsd_mode_t    mode = PWSD_MODE_COMPAT;
	logic          irq_en = 1'b0;
	logic          sp_start = 1'b0;
	logic          ack_start = 1'b0;
	logic [3:0]    want = 4'hF;
	logic [7:0]    rdata;
	pwsd_lines_t   lines;
	logic          sp_out, ack_out, irq, srst;
	int            errors = 0;
	int            tests_run = 0;
	always #20 clk = ~clk;
	pwsd_host_model u_pwsd_host_model (.want(want), .lines(lines));
	pwsd_regs #(.RESET_CLKS(2)) u_pwsd_regs (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
		.channel_select(chan), .bus_rdata(rdata), .port_mode(mode),
		.signal_change_irq_enable(irq_en), .host_lines(lines), .short_pulse_start(sp_start),
		.ack_pulse_start(ack_start), .short_pulse_out(sp_out), .ack_pulse_out(ack_out),
		.signal_change_irq(irq), .soft_reset_out(srst));
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		bus_req <= '0;
		@(posedge clk);
		#1 chk(exp, rdata);
	endtask
	task automatic pulse(input logic ack, input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		@(posedge clk);
		ack_start <= ack;
		sp_start <= !ack;
		@(posedge clk);
		ack_start <= 1'b0;
		sp_start <= 1'b0;
		repeat (20)
		begin
			@(posedge clk) #1;
			n = n + {7'h00, ack ? ack_out : sp_out};
		end
		chk(exp, n);
	endtask
	task automatic wait_srst(input logic v);
		#1;
		repeat (40)
			if (srst !== v)
				@(posedge clk) #1;
		chk({7'h00, v}, {7'h00, srst});
	endtask
	task automatic final_report;
		$display("Checks %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#100000;
		errors++;
		final_report;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFF_PULSE_WIDTH, PULSE_WIDTH_RESET);
		rd(OFF_LINE_STATUS, REG_RESET);
		rd(OFF_SOFT_RESET, REG_RESET);
		rd(8'h10, 8'h00);
		wr(OFF_FALL_ENABLE, 8'h0F);
		rd(OFF_FALL_ENABLE, 8'h0F);
		@(posedge clk);
		mode <= PWSD_MODE_NIBBLE_BYTE;
		wr(OFF_PULSE_WIDTH, 8'(SHORT_PULSE_CLKS - 2));
		pulse(1'b0, 8'(SHORT_PULSE_CLKS - 2));
		@(posedge clk);
		mode <= PWSD_MODE_ECP_EPP;
		wr(OFF_PULSE_WIDTH, 8'h03);
		pulse(1'b0, 8'h03);
		@(posedge clk);
		mode <= PWSD_MODE_COMPAT;
		wr(OFF_PULSE_WIDTH, 8'h05);
		pulse(1'b1, 8'h05);
		wr(OFF_PULSE_WIDTH, 8'h12);
		pulse(1'b1, 8'h12);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFF_PULSE_WIDTH, PULSE_WIDTH_RESET);
		rd(OFF_FALL_ENABLE, REG_RESET);
		wr(OFF_FALL_ENABLE, 8'h05);
		wr(OFF_RISE_ENABLE, 8'h02);
		irq_en <= 1'b1;
		want <= 4'h0;
		repeat (10) @(posedge clk);
		rd(OFF_LINE_STATUS, 8'h00);
		@(posedge clk);
		want <= 4'hF;
		mode <= PWSD_MODE_MANUAL;
		repeat (10) @(posedge clk);
		rd(OFF_LINE_STATUS, 8'h02);
		wr(OFF_LINE_STATUS, 8'hA0);
		rd(OFF_LINE_STATUS, 8'h00);
		chk(8'h00, {7'h00, irq});
		@(posedge clk);
		want <= 4'h0;
		repeat (10) @(posedge clk);
		#1 chk(8'h01, {7'h00, irq});
		@(posedge clk);
		irq_en <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(8'h00, {7'h00, irq});
		@(posedge clk);
		irq_en <= 1'b1;
		rd(OFF_LINE_STATUS, 8'h05);
		@(posedge clk);
		chan <= 2'h1;
		wr(OFF_SOFT_RESET, SOFT_RESET_CODE);
		chan <= CHAN_RESET_LO;
		wr(OFF_SOFT_RESET, 8'h80);
		repeat (4) @(posedge clk);
		#1 chk(8'h00, {7'h00, srst});
		wr(OFF_SOFT_RESET, SOFT_RESET_CODE);
		wait_srst(1'b1);
		wait_srst(1'b0);
		rd(OFF_FALL_ENABLE, REG_RESET);
		rd(OFF_RISE_ENABLE, REG_RESET);
		final_report;
	end
endmodule
